// File: tim_ctrl.sv
// Purpose: translation cache with invalidation triggers and memory type range map
// Assumes: fills come from an external page walker; one request of each kind per cycle
// Notes: lookup answer and fault are registered, one cycle after the request
`timescale 1ns/100ps

// Notes on behaviour
// - cache fills on miss from walker data with no software action.
// - single page invalidate removes only that page, global or not.
// - entry keeps global attribute taken from the table entry it came from.
// - page table base write flushes every non-global entry.
// - task switch loading a different base flushes non-global entries.
// - either edge of flush pin flushes all entries including global.
// - any range register write with a legal type flushes all entries including global.
// - primary control write changing paging or protection enable flushes all.
// - extended control write changing large page, global page or extension flushes all.
// - up to 96 typed ranges: 88 fixed fields plus 8 variable.
// - reset disables all range registers, so every address is uncacheable.
// - type encodings are 00H, 01H, 04H, 05H and 06H.
// - reserved type encodings on write raise a protection fault.
// - when enabled, uncovered addresses take the default type.
module tim_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // external flush pin, active low, asynchronous
  input wire logic flush_n,
  // control register writes from the core
  input wire logic primary_control_wr,
  input wire logic [31:0] primary_control_data,
  input wire logic extended_control_wr,
  input wire logic [31:0] extended_control_data,
  input wire logic page_table_base_wr,
  input wire logic task_switch_base_wr,
  input wire logic [31:0] page_table_base_data,
  // single page invalidate
  input wire logic page_invalidate_cmd,
  input wire logic [tim_pkg::PAGE_W-1:0] page_invalidate_page,
  // range register write (model register write command)
  input wire tim_pkg::tim_range_wr_t model_reg_write_cmd,
  // lookup and fill
  input wire logic lookup_req,
  input wire logic [tim_pkg::PAGE_W-1:0] lookup_vpage,
  input wire tim_pkg::tim_fill_t fill,
  // answers
  output tim_pkg::tim_lookup_t lookup_rsp,
  output logic lookup_valid,
  output logic walk_req,
  output logic [tim_pkg::PAGE_W-1:0] walk_vpage,
  output logic general_protection_fault,
  output logic tlb_flushed,
  output logic [31:0] primary_control_reg,
  output logic [31:0] extended_control_reg,
  output logic [31:0] page_table_base_reg
);

  // ==========================================================================
  // flush pin synchroniser: three stages, change counts when 2nd and 3rd agree
  logic flush_s1;
  logic flush_s2;
  logic flush_s3;
  logic flush_level;
  logic flush_edge;

  always_ff @(posedge clk) begin
    flush_s1 <= flush_n;
    flush_s2 <= flush_s1;
    flush_s3 <= flush_s2;
  end

  // filtered level; reset to the idle (high) pin level so release is no edge
  always_ff @(posedge clk) begin
    if (srst) begin
      flush_level <= 1'b1;
    end else if (flush_s2 == flush_s3) begin
      flush_level <= flush_s3;
    end
  end

  assign flush_edge = !srst && (flush_s2 == flush_s3) && (flush_s3 != flush_level);

  // ==========================================================================
  // range register write checks
  logic range_legal;
  logic range_wr_ok;

  // only the type field is checked; base and mask are taken as given
  assign range_legal = tim_pkg::tim_type_legal(model_reg_write_cmd.mem_type);
  assign range_wr_ok = model_reg_write_cmd.valid && range_legal;

  // fault pulse on a reserved encoding
  always_ff @(posedge clk) begin
    if (srst) begin
      general_protection_fault <= 1'b0;
    end else begin
      general_protection_fault <= model_reg_write_cmd.valid && !range_legal;
    end
  end

  // ==========================================================================
  // invalidation triggers
  logic [31:0] primary_diff;
  logic [31:0] ext_diff;
  logic flush_all;
  logic flush_nonglobal;
  logic any_inval;

  assign primary_diff = primary_control_data ^ primary_control_reg;
  assign ext_diff = extended_control_data ^ extended_control_reg;

  assign flush_all = flush_edge || range_wr_ok ||
    (primary_control_wr && (primary_diff[tim_pkg::PRIMARY_PG_POS] ||
      primary_diff[tim_pkg::PRIMARY_PE_POS])) ||
    (extended_control_wr && (ext_diff[tim_pkg::EXT_PSE_POS] ||
      ext_diff[tim_pkg::EXT_PGE_POS] || ext_diff[tim_pkg::EXT_PAE_POS]));
  assign flush_nonglobal = page_table_base_wr ||
    (task_switch_base_wr && (page_table_base_data != page_table_base_reg));
  assign any_inval = flush_all || flush_nonglobal || page_invalidate_cmd;

  // control registers
  always_ff @(posedge clk) begin
    if (srst) begin
      primary_control_reg <= tim_pkg::CTRL_RESET;
      extended_control_reg <= tim_pkg::CTRL_RESET;
      page_table_base_reg <= tim_pkg::CTRL_RESET;
    end else begin
      if (primary_control_wr) begin
        primary_control_reg <= primary_control_data;
      end
      if (extended_control_wr) begin
        extended_control_reg <= extended_control_data;
      end
      if (page_table_base_wr || task_switch_base_wr) begin
        page_table_base_reg <= page_table_base_data;
      end
    end
  end

  // ==========================================================================
  // range map storage
  logic [7:0] fix_type [tim_pkg::FIX_FIELDS];
  logic [7:0] var_type [tim_pkg::VAR_RANGES];
  logic [tim_pkg::PAGE_W-1:0] var_base [tim_pkg::VAR_RANGES];
  logic [tim_pkg::PAGE_W-1:0] var_mask [tim_pkg::VAR_RANGES];
  logic [tim_pkg::VAR_RANGES-1:0] var_valid;
  logic [7:0] def_type;
  logic map_enable;
  logic fix_enable;

  // fixed, variable and default registers share one write path; 88 + 8 ranges
  always_ff @(posedge clk) begin
    if (srst) begin
      def_type <= tim_pkg::DEF_TYPE_RESET;
      map_enable <= 1'b0;
      fix_enable <= 1'b0;
      var_valid <= '0;
      for (int i = 0; i < tim_pkg::FIX_FIELDS; i++) begin
        fix_type[i] <= tim_pkg::TYPE_UNCACHEABLE;
      end
      for (int i = 0; i < tim_pkg::VAR_RANGES; i++) begin
        var_type[i] <= tim_pkg::TYPE_UNCACHEABLE;
        var_base[i] <= '0;
        var_mask[i] <= '0;
      end
    end else if (range_wr_ok) begin
      case (model_reg_write_cmd.target)
        tim_pkg::TIM_TGT_DEFAULT: begin
          def_type <= model_reg_write_cmd.mem_type;
          map_enable <= model_reg_write_cmd.enable;
          fix_enable <= model_reg_write_cmd.fixed_enable;
        end
        tim_pkg::TIM_TGT_FIXED: begin
          if (model_reg_write_cmd.index < 7'(tim_pkg::FIX_FIELDS)) begin
            fix_type[model_reg_write_cmd.index] <= model_reg_write_cmd.mem_type;
          end
        end
        tim_pkg::TIM_TGT_VAR: begin
          var_type[model_reg_write_cmd.index[tim_pkg::VAR_IDX_W-1:0]] <=
            model_reg_write_cmd.mem_type;
          var_base[model_reg_write_cmd.index[tim_pkg::VAR_IDX_W-1:0]] <=
            model_reg_write_cmd.base;
          var_mask[model_reg_write_cmd.index[tim_pkg::VAR_IDX_W-1:0]] <=
            model_reg_write_cmd.mask;
          var_valid[model_reg_write_cmd.index[tim_pkg::VAR_IDX_W-1:0]] <=
            model_reg_write_cmd.enable;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // type resolution for a physical page
  // fixed fields: 8 x 64K, 16 x 16K, 64 x 4K below 1 MByte
  function automatic logic [tim_pkg::FIX_IDX_W-1:0] fix_index(
    input logic [tim_pkg::PAGE_W-1:0] pg);
    if (pg[7:4] < 4'h8) begin
      return {4'h0, pg[6:4]};
    end else if (pg[7:4] < 4'hC) begin
      return 7'(8 + {3'h0, pg[5:2]});
    end else begin
      return 7'(24 + {1'b0, pg[5:0]});
    end
  endfunction

  logic [tim_pkg::PAGE_W-1:0] res_page;
  logic [7:0] res_type;

  // overlap handling is simplified: lowest numbered variable range wins
  always_comb begin
    logic var_hit;
    var_hit = 1'b0;
    res_type = tim_pkg::TYPE_UNCACHEABLE;
    if (map_enable) begin
      res_type = def_type;
      for (int i = tim_pkg::VAR_RANGES - 1; i >= 0; i--) begin
        if (var_valid[i] && ((res_page & var_mask[i]) == (var_base[i] & var_mask[i]))) begin
          res_type = var_type[i];
          var_hit = 1'b1;
        end
      end
      if (fix_enable && (res_page[tim_pkg::PAGE_W-1:8] == '0)) begin
        res_type = fix_type[fix_index(res_page)];
      end
    end
  end

  // ==========================================================================
  // translation cache
  logic [tim_pkg::TLB_ENTRIES-1:0] tlb_valid;
  logic [tim_pkg::TLB_ENTRIES-1:0] tlb_global;
  logic [tim_pkg::PAGE_W-1:0] tlb_vpage [tim_pkg::TLB_ENTRIES];
  logic [tim_pkg::PAGE_W-1:0] tlb_ppage [tim_pkg::TLB_ENTRIES];
  logic [tim_pkg::TLB_IDX_W-1:0] repl_ptr;
  logic hit;
  logic [tim_pkg::TLB_IDX_W-1:0] hit_idx;

  // fully associative match
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < tim_pkg::TLB_ENTRIES; i++) begin
      if (tlb_valid[i] && (tlb_vpage[i] == lookup_vpage)) begin
        hit = 1'b1;
        hit_idx = i[tim_pkg::TLB_IDX_W-1:0];
      end
    end
  end

  assign res_page = tlb_ppage[hit_idx];

  // entry valid and global bits; invalidation beats a fill in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      tlb_valid <= '0;
      tlb_global <= '0;
      repl_ptr <= '0;
    end else begin
      if (fill.valid && !any_inval) begin
        tlb_valid[repl_ptr] <= 1'b1;
        tlb_global[repl_ptr] <= fill.global_flag;
        repl_ptr <= repl_ptr + 1'b1;
      end
      for (int i = 0; i < tim_pkg::TLB_ENTRIES; i++) begin
        if (flush_all) begin
          tlb_valid[i] <= 1'b0;
        end else if (flush_nonglobal && !tlb_global[i]) begin
          tlb_valid[i] <= 1'b0;
        end else if (page_invalidate_cmd && (tlb_vpage[i] == page_invalidate_page)) begin
          tlb_valid[i] <= 1'b0;
        end
      end
    end
  end

  // entry payload
  always_ff @(posedge clk) begin
    if (fill.valid && !any_inval) begin
      tlb_vpage[repl_ptr] <= fill.vpage;
      tlb_ppage[repl_ptr] <= fill.ppage;
    end
  end

  // ==========================================================================
  // registered answers
  always_ff @(posedge clk) begin
    if (srst) begin
      lookup_rsp <= '0;
      lookup_valid <= 1'b0;
      walk_req <= 1'b0;
      walk_vpage <= '0;
      tlb_flushed <= 1'b0;
    end else begin
      lookup_valid <= lookup_req;
      lookup_rsp.hit <= lookup_req && hit && !any_inval;
      lookup_rsp.ppage <= res_page;
      lookup_rsp.mem_type <= res_type;
      walk_req <= lookup_req && !(hit && !any_inval);
      walk_vpage <= lookup_vpage;
      tlb_flushed <= flush_all || flush_nonglobal;
    end
  end

endmodule // tim_ctrl

// File: tim_pkg.sv
// Purpose: shared constants and types for the translation invalidate and range type block
// Assumes: 32-bit linear and physical addresses, 4 KByte pages
// Notes: type encodings match the range type register field layout
package tim_pkg;

  // ==========================================================================
  // geometry
  localparam int TLB_ENTRIES = 16;
  localparam int TLB_IDX_W = 4;
  localparam int PAGE_W = 20;
  localparam int VAR_RANGES = 8;
  localparam int VAR_IDX_W = 3;
  localparam int FIX_FIELDS = 88;
  localparam int FIX_IDX_W = 7;
  localparam int TOTAL_RANGES = 96;

  // ==========================================================================
  // memory type encodings
  localparam logic [7:0] TYPE_UNCACHEABLE = 8'h00;
  localparam logic [7:0] TYPE_WRITE_COMBINING = 8'h01;
  localparam logic [7:0] TYPE_WRITE_THROUGH = 8'h04;
  localparam logic [7:0] TYPE_WRITE_PROTECTED = 8'h05;
  localparam logic [7:0] TYPE_WRITE_BACK = 8'h06;

  // ==========================================================================
  // control register bit positions
  localparam int PRIMARY_PE_POS = 0;
  localparam int PRIMARY_PG_POS = 31;
  localparam int EXT_PSE_POS = 4;
  localparam int EXT_PAE_POS = 5;
  localparam int EXT_PGE_POS = 7;

  // ==========================================================================
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] DEF_TYPE_RESET = 8'h00;

  // range register write target
  typedef enum logic [1:0] {
    TIM_TGT_DEFAULT = 2'h0,
    TIM_TGT_FIXED = 2'h1,
    TIM_TGT_VAR = 2'h2
  } tim_tgt_t;

  // range register write command
  typedef struct packed {
    logic valid;
    tim_tgt_t target;
    logic [FIX_IDX_W-1:0] index;
    logic [7:0] mem_type;
    logic [PAGE_W-1:0] base;
    logic [PAGE_W-1:0] mask;
    logic enable;
    logic fixed_enable;
  } tim_range_wr_t;

  // translation fill from the page walker
  typedef struct packed {
    logic valid;
    logic [PAGE_W-1:0] vpage;
    logic [PAGE_W-1:0] ppage;
    logic global_flag;
  } tim_fill_t;

  // lookup answer
  typedef struct packed {
    logic hit;
    logic [PAGE_W-1:0] ppage;
    logic [7:0] mem_type;
  } tim_lookup_t;

  // legal type check, shared by every type field write
  function automatic logic tim_type_legal(input logic [7:0] t);
    return (t == TYPE_UNCACHEABLE) || (t == TYPE_WRITE_COMBINING) ||
           (t == TYPE_WRITE_THROUGH) || (t == TYPE_WRITE_PROTECTED) ||
           (t == TYPE_WRITE_BACK);
  endfunction

endpackage

// File: tim_ctrl_assertions.sv
// Purpose: port-level checker for the translation invalidate and range type block
// Assumes: answers and write-caused flush pulses are registered one cycle after their cause; pin edges get 2 to 5 cycles
// Notes: sees only top ports; attached by bind at the foot of this file
`timescale 1ns/100ps
module tim_ctrl_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // triggers
  input wire logic flush_n,
  input wire logic primary_control_wr,
  input wire logic [31:0] primary_control_data,
  input wire logic extended_control_wr,
  input wire logic [31:0] extended_control_data,
  input wire logic page_table_base_wr,
  input wire logic page_invalidate_cmd,
  input wire tim_pkg::tim_range_wr_t model_reg_write_cmd,
  // lookup side
  input wire logic lookup_req,
  input wire logic [tim_pkg::PAGE_W-1:0] lookup_vpage,
  input wire tim_pkg::tim_lookup_t lookup_rsp,
  input wire logic lookup_valid,
  input wire logic walk_req,
  input wire logic [tim_pkg::PAGE_W-1:0] walk_vpage,
  // answers and register copies
  input wire logic general_protection_fault,
  input wire logic tlb_flushed,
  input wire logic [31:0] primary_control_reg,
  input wire logic [31:0] extended_control_reg
);
  // ==========================================================================
  // helpers: legal and refused range writes, control bits that flush
  logic bad;
  logic good;
  logic prim_chg;
  logic ext_chg;
  assign bad = model_reg_write_cmd.valid &&
    !(model_reg_write_cmd.mem_type inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06});
  assign good = model_reg_write_cmd.valid && !bad;
  assign prim_chg = primary_control_wr && ((primary_control_data[31] != primary_control_reg[31])
    || (primary_control_data[0] != primary_control_reg[0]));
  assign ext_chg = extended_control_wr &&
    ((extended_control_data[7:4] ^ extended_control_reg[7:4]) & 4'hB) != 4'h0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ==========================================================================
  // properties
  sequence s_miss;
    lookup_req ##1 walk_req;
  endsequence
  sequence s_pin_edge;
    $changed(flush_n);
  endsequence
  property p_ans; lookup_req |=> lookup_valid; endproperty
  property p_walk; s_miss |-> walk_vpage == $past(lookup_vpage) && !lookup_rsp.hit; endproperty
  property p_same;
    lookup_req && (page_invalidate_cmd || page_table_base_wr || good) |=> !lookup_rsp.hit;
  endproperty
  property p_base; page_table_base_wr |=> tlb_flushed; endproperty
  property p_range; good |=> tlb_flushed; endproperty
  property p_prim; prim_chg |=> tlb_flushed; endproperty
  property p_ext; ext_chg |=> tlb_flushed; endproperty
  property p_pin; s_pin_edge |-> ##[2:5] tlb_flushed; endproperty
  property p_fault; bad |=> general_protection_fault; endproperty
  property p_fault_src; general_protection_fault |-> $past(bad); endproperty

  a_ans: assert property (p_ans) else $error("lookup not answered");
  a_walk: assert property (p_walk) else $error("walk page wrong");
  a_same: assert property (p_same) else $error("hit during invalidate");
  a_base: assert property (p_base) else $error("base write no flush");
  a_range: assert property (p_range) else $error("range write no flush");
  a_prim: assert property (p_prim) else $error("primary change no flush");
  a_ext: assert property (p_ext) else $error("extended change no flush");
  a_pin: assert property (p_pin) else $error("flush pin edge ignored");
  a_fault: assert property (p_fault) else $error("reserved type not faulted");
  a_fault_src: assert property (p_fault_src) else $error("fault without cause");
endmodule // tim_ctrl_assertions

bind tim_ctrl tim_ctrl_assertions tim_ctrl_assertions_i (.*);

// File: tim_walker_model.sv
// Purpose: page walker model answering translation misses
// Assumes: the walker answers on the edge after a miss is reported
// Notes: idle fill fields are inverted each cycle so stale data never passes
`timescale 1ns/100ps
module tim_walker_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // miss request from the block
  input wire logic walk_req,
  input wire logic [tim_pkg::PAGE_W-1:0] walk_vpage,
  // global attribute of the walked table entry
  input wire logic global_in,
  // fill answer
  output tim_pkg::tim_fill_t fill
);
  // ==========================================================================
  // fixed xor mapping keeps the bench able to predict every translation
  always_ff @(posedge clk) begin
    if (srst) begin
      fill <= '0;
    end else if (walk_req) begin
      fill <= '{valid: 1'b1, vpage: walk_vpage, ppage: walk_vpage ^ 20'h80000,
        global_flag: global_in};
    end else begin
      fill <= '{valid: 1'b0, vpage: ~fill.vpage, ppage: ~fill.ppage,
        global_flag: ~fill.global_flag};
    end
  end
endmodule // tim_walker_model

// File: tb_tim_ctrl.sv
// Purpose: self-checking bench for the translation invalidate and range type block
// Assumes: inputs change 1 ns after the rising edge; answers read in that cycle
// Notes: translations come from the walker model as vpage xor 80000H
`timescale 1ns/100ps
module tb_tim_ctrl;
  // ==========================================================================
  // signals
  logic clk, srst, flush_n, primary_control_wr, extended_control_wr, page_table_base_wr;
  logic task_switch_base_wr, page_invalidate_cmd, lookup_req, lookup_valid, walk_req;
  logic general_protection_fault, tlb_flushed, global_in, legal;
  logic [31:0] primary_control_data, extended_control_data, page_table_base_data;
  logic [31:0] primary_control_reg, extended_control_reg, page_table_base_reg, ext;
  logic [tim_pkg::PAGE_W-1:0] page_invalidate_page, lookup_vpage, walk_vpage;
  logic [7:0] last, t;
  tim_pkg::tim_range_wr_t model_reg_write_cmd;
  tim_pkg::tim_fill_t fill;
  tim_pkg::tim_lookup_t lookup_rsp;
  int error_cnt, checks;
  int pos [3] = '{tim_pkg::EXT_PSE_POS, tim_pkg::EXT_PGE_POS, tim_pkg::EXT_PAE_POS};

  tim_ctrl tim_ctrl_i (.*);
  tim_walker_model tim_walker_model_i (.*);

  always #5 clk = ~clk;

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic lk(input logic [19:0] vp);
    lookup_req = 1'b1;
    lookup_vpage = vp;
    tick();
    lookup_req = 1'b0;
  endtask
  // the walker answers a miss, two edges later the entry is stored
  task automatic prime(input logic [19:0] vp, input logic g);
    global_in = g;
    lk(vp);
    tick();
    tick();
  endtask
  // one lookup judged while its answer stands; the idle cycle after it keeps
  // the next request from raising lookup_req in the step that lowered it
  task automatic hitchk(input logic [19:0] vp, input logic exp, input logic [7:0] ty = 8'h00);
    lk(vp);
    check(lookup_valid, 1'b1);
    check(lookup_rsp.hit, exp);
    if (exp) begin
      check(lookup_rsp.ppage, vp ^ 20'h80000);
      check(lookup_rsp.mem_type, ty);
    end
    tick();
  endtask
  // whole command in one assignment so valid is written once per step
  task automatic wr_range(input tim_pkg::tim_tgt_t tgt, input logic [7:0] ty,
    input logic [6:0] idx = 7'h00, input logic [19:0] bs = 20'h00000,
    input logic [19:0] mk = 20'h00000, input logic fe = 1'b0);
    model_reg_write_cmd = '{valid: 1'b1, target: tgt, index: idx, mem_type: ty, base: bs,
      mask: mk, enable: 1'b1, fixed_enable: fe};
    tick();
    model_reg_write_cmd.valid = 1'b0;
  endtask
  task automatic summarize();
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_page_inv();
    prime(20'h00012, 1'b1);
    prime(20'h00013, 1'b0);
    page_invalidate_cmd = 1'b1;
    page_invalidate_page = 20'h00012;
    tick();
    page_invalidate_cmd = 1'b0;
    hitchk(20'h00012, 1'b0);
    hitchk(20'h00013, 1'b1);
  endtask
  task automatic t_base();
    prime(20'h00021, 1'b1);
    prime(20'h00022, 1'b0);
    page_table_base_data = 32'h0000_1000;
    page_table_base_wr = 1'b1;
    tick();
    page_table_base_wr = 1'b0;
    check(tlb_flushed, 1'b1);
    hitchk(20'h00021, 1'b1);
    hitchk(20'h00022, 1'b0);
    for (int k = 0; k < 2; k++) begin
      prime(20'h00022, 1'b0);
      page_table_base_data = (k == 0) ? 32'h0000_1000 : 32'h0000_2000;
      task_switch_base_wr = 1'b1;
      tick();
      task_switch_base_wr = 1'b0;
      hitchk(20'h00022, k == 0);
    end
    hitchk(20'h00021, 1'b1);
    check(page_table_base_reg, 32'h0000_2000);
  endtask
  // every trigger that also removes global entries
  task automatic t_full();
    for (int k = 0; k < 8; k++) begin
      prime(20'h00031, 1'b1);
      case (k)
        0: flush_n = 1'b0;
        1: flush_n = 1'b1;
        2: wr_range(tim_pkg::TIM_TGT_FIXED, tim_pkg::TYPE_WRITE_BACK);
        3, 7: begin
          primary_control_wr = 1'b1;
          primary_control_data = 32'h8000_0001;
        end
        default: begin
          ext = ext ^ (32'h0000_0001 << pos[k-4]);
          extended_control_wr = 1'b1;
          extended_control_data = ext;
        end
      endcase
      tick();
      primary_control_wr = 1'b0;
      extended_control_wr = 1'b0;
      repeat (5) tick();
      hitchk(20'h00031, k == 7);
    end
    check(primary_control_reg, 32'h8000_0001);
    check(extended_control_reg, ext);
  endtask
  // type codes 00H to 08H and FFH, legal and reserved, through the default type field
  task automatic t_types();
    for (int k = 0; k < 10; k++) begin
      t = (k == 9) ? 8'hFF : 8'(k);
      legal = t inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
      prime(20'h00041, 1'b0);
      wr_range(tim_pkg::TIM_TGT_DEFAULT, t);
      check(general_protection_fault, !legal);
      check(tlb_flushed, legal);
      hitchk(20'h00041, !legal, last);
      if (legal) last = t;
      tick();
      tick();
      hitchk(20'h00041, 1'b1, last);
    end
  endtask
  // range map resolution: fixed over variable over default; default is 06 here
  task automatic t_map();
    wr_range(tim_pkg::TIM_TGT_VAR, tim_pkg::TYPE_WRITE_THROUGH, 7'h00, 20'h80000, 20'hFFF00);
    tick();
    wr_range(tim_pkg::TIM_TGT_VAR, tim_pkg::TYPE_WRITE_COMBINING, 7'h01, 20'h00000, 20'hFFF00);
    tick();
    wr_range(tim_pkg::TIM_TGT_FIXED, tim_pkg::TYPE_WRITE_PROTECTED, 7'h00);
    tick();
    wr_range(tim_pkg::TIM_TGT_FIXED, tim_pkg::TYPE_WRITE_THROUGH, 7'h1B);
    tick();
    wr_range(tim_pkg::TIM_TGT_FIXED, tim_pkg::TYPE_WRITE_BACK, 7'h58);
    check(tlb_flushed, 1'b1);
    prime(20'h00061, 1'b0);
    hitchk(20'h00061, 1'b1, 8'h04);
    prime(20'h00161, 1'b0);
    hitchk(20'h00161, 1'b1, 8'h06);
    prime(20'h80005, 1'b0);
    hitchk(20'h80005, 1'b1, 8'h01);
    wr_range(tim_pkg::TIM_TGT_DEFAULT, tim_pkg::TYPE_WRITE_BACK, 7'h00, 20'h00000, 20'h00000,
      1'b1);
    prime(20'h80005, 1'b0);
    hitchk(20'h80005, 1'b1, 8'h05);
    prime(20'h800C3, 1'b0);
    hitchk(20'h800C3, 1'b1, 8'h04);
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    {clk, primary_control_wr, extended_control_wr, page_table_base_wr} = 4'h0;
    {task_switch_base_wr, page_invalidate_cmd, lookup_req, global_in} = 4'h0;
    {primary_control_data, extended_control_data, page_table_base_data, ext} = '0;
    {page_invalidate_page, lookup_vpage, last} = '0;
    model_reg_write_cmd = '0;
    error_cnt = 0;
    checks = 0;
    flush_n = 1'b1;
    srst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    srst = 1'b0;
    prime(20'h00011, 1'b0);
    hitchk(20'h00011, 1'b1, 8'h00);
    t_page_inv();
    t_base();
    t_full();
    prime(20'h00051, 1'b0);
    lookup_req = 1'b1;
    page_invalidate_cmd = 1'b1;
    page_invalidate_page = 20'h00052;
    tick();
    {lookup_req, page_invalidate_cmd} = 2'h0;
    check(lookup_rsp.hit, 1'b0);
    tick();
    tick();
    t_types();
    t_map();
    summarize();
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule // tb_tim_ctrl
